/* File: hdl/rscs_sequencer.sv */
`timescale 1ns/100ps
// Operation
// - every received byte outside sleep is written to the buffer whatever the crc result
// - overlong receive packets keep writing past rx region into tx area
// - regulator command byte 0 selects linear only, 1 adds buck in active states; here taken only in STANDBY_RC, and BUCK_EN then holds in every state
// - after reset only the linear regulator is used
// - reset triggers automatic image calibration over the default band
// - image calibration command is opcode, lower bound, upper bound
// - completed calibration covers every frequency between the two bounds
// - with switch control on, pin is 1 from tx request until pa ramped down, 0 when idle or in sleep
// - pin rises before pa ramp up and falls after ramp down
// - switch config byte 0x00 frees pin for irq, 0x01 gives switch control
// - other commands are accepted in any order, but protocol, modulation and frame set CFG_COMPLETE only in that order
// - a shared 256-byte buffer serves transmit and receive, not in sleep
module rscs_sequencer #(
    parameter int CAL_CYCLES  = rscs_pkg::CAL_CYC,
    parameter int LEAD_CYCLES = rscs_pkg::LEAD_CYC
) (
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    input  wire logic       CMD_VALID,
    input  wire logic [7:0] CMD_BYTE,
    input  wire logic       CMD_END,
    input  wire logic       SLEEP_MODE,
    input  wire logic       STANDBY_RC,
    input  wire logic       TX_REQ,
    input  wire logic       PA_RAMPED_DOWN,
    input  wire logic       IRQ_LEVEL,
    input  wire logic       RX_BYTE_VALID,
    input  wire logic [7:0] RX_BYTE,
    input  wire logic       RX_START,
    input  wire logic [7:0] RD_ADDR,
    output logic            BUSY,
    output logic            BUCK_EN,
    output logic            CAL_VALID,
    output logic [7:0]      CAL_LO,
    output logic [7:0]      CAL_HI,
    output logic            RF_SWITCH_PIN,
    output logic            PA_RAMP_START,
    output logic            CFG_COMPLETE,
    output logic [7:0]      RD_DATA
);
    logic [7:0]         op_ff;
    logic [1:0]         idx_ff;
    logic [7:0]         p1_ff;
    logic               buck_ff;
    logic               sw_en_ff;
    logic               cal_run_ff;
    logic               cal_ok_ff;
    logic [7:0]         lo_ff;
    logic [7:0]         hi_ff;
    logic [31:0]        cal_cnt_ff;
    logic [1:0]         cfg_ff;
    logic               cfg_done_ff;
    logic [7:0]         cur_op;
    logic [7:0]         rx_base_ff;
    logic [7:0]         tx_base_ff;
    logic [7:0]         wptr_ff;
    logic               busy_ff;
    logic               pin_ff;
    logic               ramp_ff;
    logic [31:0]        lead_ff;
    rscs_pkg::rscs_rf_t rf_ff;
    logic               done_cmd;
    logic [7:0]         buf_q;
    initial begin
        if (CAL_CYCLES < 1 || LEAD_CYCLES < 1) $error("cycle counts must be at least one");
    end
    assign done_cmd = CMD_VALID && CMD_END && !busy_ff;
    // opcode of the command ending now, also when it is a single byte
    assign cur_op   = (idx_ff == 2'h0) ? CMD_BYTE : op_ff;
    // command byte capture
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            idx_ff <= 2'h0;
            op_ff  <= 8'h00;
            p1_ff  <= 8'h00;
        end else if (CMD_VALID && !busy_ff) begin
            if (CMD_END) begin
                idx_ff <= 2'h0;
            end else begin
                idx_ff <= (idx_ff == 2'h3) ? idx_ff : idx_ff + 2'h1;
            end
            if (idx_ff == 2'h0) begin
                op_ff <= CMD_BYTE;
            end
            if (idx_ff == 2'h1) begin
                p1_ff <= CMD_BYTE;
            end
        end
    end
    // regulator and switch configuration
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            buck_ff  <= 1'b0;
            sw_en_ff <= 1'b0;
        end else if (done_cmd && idx_ff == 2'h1) begin
            if (op_ff == rscs_pkg::OP_REGULATOR && STANDBY_RC) begin
                buck_ff <= CMD_BYTE[0];
            end
            if (op_ff == rscs_pkg::OP_SWITCH_CFG) begin
                sw_en_ff <= (CMD_BYTE == rscs_pkg::SW_ENABLE);
            end
        end
    end
    // image calibration, including the one after reset
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cal_run_ff <= 1'b1;
            cal_ok_ff  <= 1'b0;
            lo_ff      <= rscs_pkg::DEF_CAL_LO;
            hi_ff      <= rscs_pkg::DEF_CAL_HI;
            cal_cnt_ff <= 32'h0;
        end else if (cal_run_ff) begin
            if (cal_cnt_ff == 32'(CAL_CYCLES - 1)) begin
                cal_run_ff <= 1'b0;
                cal_ok_ff  <= 1'b1;
            end else begin
                cal_cnt_ff <= cal_cnt_ff + 32'h1;
            end
        end else if (done_cmd && idx_ff == 2'h2 && op_ff == rscs_pkg::OP_IMAGE_CAL) begin
            lo_ff      <= p1_ff;
            hi_ff      <= CMD_BYTE;
            cal_run_ff <= 1'b1;
            cal_ok_ff  <= 1'b0;
            cal_cnt_ff <= 32'h0;
        end
    end
    // radio configuration order tracking; others do not matter
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cfg_ff      <= rscs_pkg::CFG_NONE;
            cfg_done_ff <= 1'b0;
        end else if (done_cmd) begin
            unique case (cur_op)
                rscs_pkg::OP_PROTOCOL: begin
                    cfg_ff      <= rscs_pkg::CFG_PROTO;
                    cfg_done_ff <= 1'b0;
                end
                rscs_pkg::OP_MODULATION: begin
                    if (cfg_ff == rscs_pkg::CFG_PROTO) cfg_ff <= rscs_pkg::CFG_MOD;
                end
                rscs_pkg::OP_FRAME: begin
                    if (cfg_ff == rscs_pkg::CFG_MOD) begin
                        cfg_ff      <= rscs_pkg::CFG_DONE;
                        cfg_done_ff <= 1'b1;
                    end
                end
                default: cfg_ff <= cfg_ff;
            endcase
        end
    end
    // buffer base offsets
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            tx_base_ff <= 8'h00;
            rx_base_ff <= 8'h00;
        end else if (done_cmd && idx_ff == 2'h2 && op_ff == rscs_pkg::OP_BUF_BASE) begin
            tx_base_ff <= p1_ff;
            rx_base_ff <= CMD_BYTE;
        end
    end
    // receive write pointer wraps freely over the whole buffer
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            wptr_ff <= 8'h00;
        end else if (RX_START) begin
            wptr_ff <= rx_base_ff;
        end else if (RX_BYTE_VALID && !SLEEP_MODE) begin
            wptr_ff <= wptr_ff + 8'h01;
        end
    end
    rscs_buffer #(
        .DEPTH (rscs_pkg::BUF_DEPTH)
    ) u_buf (
        .clk      (CLK),
        .we       (RX_BYTE_VALID && !SLEEP_MODE),
        .waddr    (wptr_ff),
        .wdata    (RX_BYTE),
        .raddr    (RD_ADDR),
        .rdata_ff (buf_q)
    );
    // busy while a command executes or calibration runs
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            busy_ff <= 1'b1;
        end else begin
            busy_ff <= cal_run_ff || done_cmd;
        end
    end
    // rf switch sequencing around pa ramps
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rf_ff   <= rscs_pkg::RF_IDLE;
            lead_ff <= 32'h0;
            ramp_ff <= 1'b0;
        end else begin
            ramp_ff <= 1'b0;
            unique case (rf_ff)
                rscs_pkg::RF_IDLE: begin
                    if (TX_REQ) begin
                        rf_ff   <= rscs_pkg::RF_LEAD;
                        lead_ff <= 32'h0;
                    end
                end
                rscs_pkg::RF_LEAD: begin
                    if (lead_ff == 32'(LEAD_CYCLES - 1)) begin
                        rf_ff   <= rscs_pkg::RF_TX;
                        ramp_ff <= 1'b1;
                    end else begin
                        lead_ff <= lead_ff + 32'h1;
                    end
                end
                rscs_pkg::RF_TX: begin
                    if (!TX_REQ) rf_ff <= rscs_pkg::RF_TAIL;
                end
                rscs_pkg::RF_TAIL: begin
                    if (PA_RAMPED_DOWN) rf_ff <= rscs_pkg::RF_IDLE;
                end
            endcase
        end
    end
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pin_ff <= 1'b0;
        end else if (sw_en_ff) begin
            pin_ff <= (rf_ff != rscs_pkg::RF_IDLE) && !SLEEP_MODE;
        end else begin
            pin_ff <= IRQ_LEVEL;
        end
    end
    assign BUSY          = busy_ff;
    assign BUCK_EN       = buck_ff;
    assign CAL_VALID     = cal_ok_ff;
    assign CAL_LO        = lo_ff;
    assign CAL_HI        = hi_ff;
    assign RF_SWITCH_PIN = pin_ff;
    assign PA_RAMP_START = ramp_ff;
    assign CFG_COMPLETE  = cfg_done_ff;
    assign RD_DATA       = buf_q;
    property p_ramp_lead;
        @(posedge CLK) disable iff (SYS_RST)
        $rose(ramp_ff) |-> pin_ff || !sw_en_ff;
    endproperty
    a_ramp_lead: assert property (p_ramp_lead) else $error("pin low at pa ramp");
    property p_reset_linear;
        @(posedge CLK) $fell(SYS_RST) |-> !buck_ff;
    endproperty
    a_reset_linear: assert property (p_reset_linear) else $error("buck on after reset");
    property p_busy_cal;
        @(posedge CLK) disable iff (SYS_RST)
        cal_run_ff |=> busy_ff;
    endproperty
    a_busy_cal: assert property (p_busy_cal) else $error("not busy in calibration");
    property p_pin_idle_low;
        @(posedge CLK) disable iff (SYS_RST)
        sw_en_ff && $past(sw_en_ff) && $past(rf_ff) == rscs_pkg::RF_IDLE |-> !pin_ff;
    endproperty
    a_pin_idle_low: assert property (p_pin_idle_low) else $error("pin high outside tx");
    property p_rx_write;
        @(posedge CLK) disable iff (SYS_RST)
        RX_BYTE_VALID && !SLEEP_MODE && !RX_START |=> wptr_ff == $past(wptr_ff) + 8'h01;
    endproperty
    a_rx_write: assert property (p_rx_write) else $error("rx pointer stalled");
    property p_cal_done;
        @(posedge CLK) disable iff (SYS_RST)
        $fell(cal_run_ff) |-> cal_ok_ff;
    endproperty
    a_cal_done: assert property (p_cal_done) else $error("calibration not valid");
    property p_reg_only_rc;
        @(posedge CLK) disable iff (SYS_RST)
        $changed(buck_ff) |-> $past(STANDBY_RC);
    endproperty
    a_reg_only_rc: assert property (p_reg_only_rc) else $error("regulator outside rc");
    property p_cfg_order;
        @(posedge CLK) disable iff (SYS_RST)
        $rose(CFG_COMPLETE) |-> $past(cfg_ff) == rscs_pkg::CFG_MOD;
    endproperty
    a_cfg_order: assert property (p_cfg_order) else $error("frame before modulation");
endmodule : rscs_sequencer

/* File: hdl/rscs_pkg.sv */
package rscs_pkg;
    localparam logic [7:0]  OP_REGULATOR  = 8'h96;
    localparam logic [7:0]  OP_IMAGE_CAL  = 8'h98;
    localparam logic [7:0]  OP_SWITCH_CFG = 8'h9d;
    localparam logic [7:0]  OP_PROTOCOL   = 8'h8a;
    localparam logic [7:0]  OP_MODULATION = 8'h8b;
    localparam logic [7:0]  OP_FRAME      = 8'h8c;
    localparam logic [7:0]  OP_BUF_BASE   = 8'h8f;
    localparam logic [7:0]  DEF_CAL_LO    = 8'he1;
    localparam logic [7:0]  DEF_CAL_HI    = 8'he9;
    localparam logic [7:0]  SW_ENABLE     = 8'h01;
    localparam int          CLK_NS        = 100;
    localparam int          CAL_US        = 100;
    localparam int          CAL_CYC       = (CAL_US * 1000) / CLK_NS;
    localparam int          LEAD_US       = 5;
    localparam int          LEAD_CYC      = (LEAD_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int          BUF_DEPTH     = 256;
    localparam logic [1:0]  CFG_NONE      = 2'h0;
    localparam logic [1:0]  CFG_PROTO     = 2'h1;
    localparam logic [1:0]  CFG_MOD       = 2'h2;
    localparam logic [1:0]  CFG_DONE      = 2'h3;
    typedef enum logic [1:0] {
        RF_IDLE = 2'b00,
        RF_LEAD = 2'b01,
        RF_TX   = 2'b10,
        RF_TAIL = 2'b11
    } rscs_rf_t;
endpackage : rscs_pkg

/* File: hdl/rscs_buffer.sv */
`timescale 1ns/100ps
module rscs_buffer #(
    parameter int DEPTH = rscs_pkg::BUF_DEPTH
) (
    input  wire logic       clk,
    input  wire logic       we,
    input  wire logic [7:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [7:0] raddr,
    output logic      [7:0] rdata_ff
);
    logic [7:0] mem [DEPTH];
    initial begin
        if (DEPTH != 256) $error("depth must be 256");
    end
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
    always_ff @(posedge clk) begin
        rdata_ff <= mem[raddr];
    end
endmodule : rscs_buffer

/* File: bench/rscs_host.sv */
`timescale 1ns/100ps
module rscs_host (
    input  wire logic       clk,
    input  wire logic       busy,
    output logic            cmd_valid,
    output logic [7:0]      cmd_byte,
    output logic            cmd_end
);
    initial begin
        cmd_valid = 1'b0;
        cmd_byte  = 8'h00;
        cmd_end   = 1'b0;
    end
    // bounded wait for ready, then one cycle of gap
    task automatic idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);
    endtask : idle
    // bytes go out back to back, end marker on the last one
    task automatic send(input int n, input logic [7:0] b0, b1, b2);
        logic [7:0] b [3];
        b = '{b0, b1, b2};
        idle();
        for (int i = 0; i < n; i++) begin
            cmd_valid = 1'b1;
            cmd_byte  = b[i];
            cmd_end   = (i == n - 1);
            @(negedge clk);
        end
        cmd_valid = 1'b0;
        cmd_byte  = ~cmd_byte;
        cmd_end   = 1'b0;
        repeat (2) @(negedge clk);
    endtask : send
    // radio configuration in its mandatory order
    task automatic setup_radio();
        send(2, rscs_pkg::OP_PROTOCOL, 8'h00, 8'h00);
        send(2, rscs_pkg::OP_MODULATION, 8'h07, 8'h00);
        send(2, rscs_pkg::OP_FRAME, 8'h08, 8'h00);
    endtask : setup_radio
endmodule : rscs_host

/* File: bench/test_rscs_sequencer.sv */
`timescale 1ns/100ps
module test_rscs_sequencer;
    logic       CLK = 0, SYS_RST = 1, CMD_VALID, CMD_END, SLEEP_MODE = 0, STANDBY_RC = 0;
    logic       TX_REQ = 0, PA_RAMPED_DOWN = 0, IRQ_LEVEL = 0, RX_BYTE_VALID = 0, RX_START = 0;
    logic [7:0] CMD_BYTE, RX_BYTE = 8'h00, RD_ADDR = 8'h00, CAL_LO, CAL_HI, RD_DATA;
    logic       BUSY, BUCK_EN, CAL_VALID, RF_SWITCH_PIN, PA_RAMP_START, CFG_COMPLETE;
    int         num_errors = 0, checked = 0, cycles = 0;
    always #50 CLK = ~CLK;
    rscs_sequencer #(.CAL_CYCLES(4), .LEAD_CYCLES(2)) uut (.CLK(CLK), .SYS_RST(SYS_RST),
        .CMD_VALID(CMD_VALID), .CMD_BYTE(CMD_BYTE), .CMD_END(CMD_END),
        .SLEEP_MODE(SLEEP_MODE), .STANDBY_RC(STANDBY_RC), .TX_REQ(TX_REQ),
        .PA_RAMPED_DOWN(PA_RAMPED_DOWN), .IRQ_LEVEL(IRQ_LEVEL), .RX_BYTE_VALID(RX_BYTE_VALID),
        .RX_BYTE(RX_BYTE), .RX_START(RX_START), .RD_ADDR(RD_ADDR), .BUSY(BUSY),
        .BUCK_EN(BUCK_EN), .CAL_VALID(CAL_VALID), .CAL_LO(CAL_LO), .CAL_HI(CAL_HI),
        .RF_SWITCH_PIN(RF_SWITCH_PIN), .PA_RAMP_START(PA_RAMP_START),
        .CFG_COMPLETE(CFG_COMPLETE), .RD_DATA(RD_DATA));
    rscs_host host (.clk(CLK), .busy(BUSY), .cmd_valid(CMD_VALID), .cmd_byte(CMD_BYTE),
        .cmd_end(CMD_END));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic results();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end
    task automatic t_reset();
        repeat (6) @(negedge CLK);
        chk(BUSY, 1); chk(BUCK_EN, 0); chk(CAL_VALID, 0);
        chk(CAL_LO, 8'he1); chk(CAL_HI, 8'he9);
        chk(RF_SWITCH_PIN, 0);
        SYS_RST = 0;
        @(negedge CLK);
        chk(BUSY, 1);
        host.idle();
        chk(CAL_VALID, 1); chk(BUCK_EN, 0);
    endtask : t_reset
    task automatic t_regulator();
        host.send(2, rscs_pkg::OP_REGULATOR, 8'h01, 8'h00);
        host.idle();
        chk(BUCK_EN, 0);
        STANDBY_RC = 1;
        host.send(2, rscs_pkg::OP_REGULATOR, 8'h01, 8'h00);
        host.idle();
        chk(BUCK_EN, 1);
        host.send(2, rscs_pkg::OP_REGULATOR, 8'h00, 8'h00);
        host.idle();
        chk(BUCK_EN, 0);
    endtask : t_regulator
    task automatic t_image_cal();
        host.send(3, rscs_pkg::OP_IMAGE_CAL, 8'hd7, 8'hdb);
        chk(BUSY, 1); chk(CAL_VALID, 0);
        chk(CAL_LO, 8'hd7); chk(CAL_HI, 8'hdb);
        host.idle();
        chk(CAL_VALID, 1); chk(CAL_HI, 8'hdb);
        chk(CAL_LO, 8'hd7);
    endtask : t_image_cal
    task automatic t_switch();
        int k;
        IRQ_LEVEL = 1;
        repeat (2) @(negedge CLK);
        chk(RF_SWITCH_PIN, 1);
        host.send(2, rscs_pkg::OP_SWITCH_CFG, rscs_pkg::SW_ENABLE, 8'h00);
        host.idle();
        chk(RF_SWITCH_PIN, 0);
        TX_REQ = 1;
        k = 0;
        while (PA_RAMP_START !== 1'b1 && k < 50) begin
            @(negedge CLK);
            k++;
        end
        chk(PA_RAMP_START, 1); chk(RF_SWITCH_PIN, 1);
        TX_REQ = 0;
        repeat (3) @(negedge CLK);
        chk(RF_SWITCH_PIN, 1);
        PA_RAMPED_DOWN = 1;
        repeat (3) @(negedge CLK);
        chk(RF_SWITCH_PIN, 0);
        PA_RAMPED_DOWN = 0;
        IRQ_LEVEL = 0;
    endtask : t_switch
    task automatic t_config();
        host.send(2, rscs_pkg::OP_FRAME, 8'h08, 8'h00);
        host.send(2, rscs_pkg::OP_MODULATION, 8'h07, 8'h00);
        host.idle();
        chk(CFG_COMPLETE, 0);
        host.setup_radio();
        host.idle();
        chk(CFG_COMPLETE, 1);
    endtask : t_config
    task automatic t_buffer();
        host.send(3, rscs_pkg::OP_BUF_BASE, 8'h10, 8'h0e);
        host.idle();
        RX_START = 1;
        @(negedge CLK);
        RX_START = 0;
        @(negedge CLK);
        for (int i = 0; i < 4; i++) begin
            RX_BYTE_VALID = 1;
            RX_BYTE = 8'ha0 + 8'(i);
            @(negedge CLK);
        end
        RX_BYTE_VALID = 0;
        for (int i = 0; i < 4; i++) begin
            RD_ADDR = 8'h0e + 8'(i);
            repeat (2) @(negedge CLK);
            chk(RD_DATA, 8'ha0 + 8'(i));
        end
        // a byte offered in sleep must not move the pointer, so the next byte lands at 0x12
        SLEEP_MODE = 1;
        RX_BYTE_VALID = 1;
        RX_BYTE = 8'h55;
        @(negedge CLK);
        SLEEP_MODE = 0;
        RX_BYTE = 8'h5a;
        @(negedge CLK);
        RX_BYTE_VALID = 0;
        RD_ADDR = 8'h12;
        repeat (2) @(negedge CLK);
        chk(RD_DATA, 8'h5a);
    endtask : t_buffer
    initial begin
        t_reset();
        t_regulator();
        t_image_cal();
        t_switch();
        t_config();
        t_buffer();
        results();
    end
endmodule : test_rscs_sequencer
